// [core/stlc_checker.sv]
// Receive-side comparator of the loopback checker, register port included.
// Assumes rx symbols and bus strobes synchronous to clk; one clock domain.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "stlc_regs.svh"
module stlc_checker import stlc_pkg::*; #(
	parameter int        PAT_DEPTH  = 16,
	parameter int        CNT_W      = 32,
	parameter int        RESYNC_RUN = `STLC_RESYNC_RUN,
	parameter logic [7:0] SKP_SYM   = 8'haa, // Arbitrary default
	parameter logic [7:0] END_SYM   = 8'he1, // Arbitrary default
	parameter logic [7:0] EIE_SYM   = 8'h00  // Arbitrary default
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire stlc_bus_req_t bus,
	output logic [31:0]        rdata,
	input  wire stlc_sym_t     rx,
	output logic               irq,
	output logic               sym_lock
);
	localparam int IW = $clog2(PAT_DEPTH);
	localparam int EN = `STLC_EV_N;
	localparam int CN = `STLC_CNT_N;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic [3:0] ones(input logic [9:0] s);
		return 4'($countones(s));
	endfunction
	function automatic logic sym_legal(input logic [9:0] s);
		return ones(s) >= 4'h4 && ones(s) <= 4'h6;
	endfunction
	function automatic logic disp_bad(input logic [9:0] s, input logic rdp);
		return (ones(s) > 4'h5 && rdp) || (ones(s) < 4'h5 && !rdp);
	endfunction
	function automatic logic rd_after(input logic [9:0] s, input logic rdp);
		return (ones(s) == 4'h5) ? rdp : (ones(s) > 4'h5);
	endfunction
	function automatic logic near8(input logic [7:0] a, input logic [7:0] b, input logic tol);
		return (a == b) || (tol && ones({2'h0, a ^ b}) == 4'h1);
	endfunction
	function automatic logic is_filler(input logic [9:0] s, input logic [9:0] f);
		return s == f || s == ~f;
	endfunction
	function automatic logic skp_len_ok(input logic usb, input logic [5:0] n);
		if (usb)
			return n >= `STLC_USB_SKP_MIN && n <= `STLC_USB_SKP_MAX && !n[0];
		return n >= `STLC_PCIE_SKP_MIN && n <= `STLC_PCIE_SKP_MAX && n[1:0] == 2'h0;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	stlc_mode_t        mode, next_mode, new_mode;
	stlc_src_t         src, next_src;
	logic              conv_user, next_conv_user, auto_sync, next_auto_sync;
	logic [EN-1:0]     status, next_status, mask, next_mask, clr_mask, reg_ev, dp_ev;
	logic [15:0]       rate, next_rate, conv, next_conv, factor;
	logic [IW:0]       patlen, next_patlen;
	logic [9:0]        filler, next_filler;
	logic [9:0]        pat [PAT_DEPTH];
	logic [9:0]        next_pat [PAT_DEPTH];
	logic [PAT_DEPTH-1:0] pat_flag, next_pat_flag;
	logic              load_rd, next_load_rd, next_irq;
	logic [31:0]       next_rdata;
	logic              sync_req, cnt_clr;
	logic [IW-1:0]     pat_idx, ptr, next_ptr, last, nptr;
	logic              aligned, next_aligned, rd_rx, next_rd_rx;
	stlc_skp_t         skp_st, next_skp_st;
	logic [5:0]        skp_len, next_skp_len;
	logic [1:0]        tail, next_tail;
	logic [7:0]        err_run, next_err_run;
	logic              frame_bad, next_frame_bad;
	logic [CNT_W-1:0]  cnt [CN];
	logic [CNT_W-1:0]  next_cnt [CN];
	logic [CNT_W-1:0]  inc [CN];
	logic [CNT_W-1:0]  ratio_num, next_ratio_num, ratio_den, next_ratio_den;
	logic [9:0]        exp_sym;
	logic [7:0]        sym8;
	logic [3:0]        be;
	logic              usb, skp_hit, end_hit, eie_hit, cmp8, adv, err_now, resync;
	stlc_cnt_t         unit;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb
	begin
		next_mode = mode;
		new_mode = stlc_mode_t'(bus.wdata[`STLC_CTRL_MODE +: 2]);
		next_src = src;
		next_conv_user = conv_user;
		next_auto_sync = auto_sync;
		next_mask = mask;
		next_rate = rate;
		next_conv = conv;
		next_patlen = patlen;
		next_filler = filler;
		next_pat = pat;
		next_pat_flag = pat_flag;
		next_load_rd = load_rd;
		clr_mask = '0;
		reg_ev = '0;
		sync_req = 1'b0;
		cnt_clr = 1'b0;
		pat_idx = bus.wdata[`STLC_PAT_IDX +: IW];
		if (bus.wr)
		begin
			unique case (bus.addr)
				`STLC_CTRL:
				begin
					// Fast links cannot be USB-aligned; keep the old mode
					if (new_mode == MODE_USB && rate > `STLC_USB_MAX_MBPS)
						reg_ev[EV_MODE] = 1'b1;
					else
					begin
						next_mode = new_mode;
						sync_req = new_mode != mode;
					end
					next_src = stlc_src_t'(bus.wdata[`STLC_CTRL_SRC +: 3]);
					next_conv_user = bus.wdata[`STLC_CTRL_CONV_USER];
					next_auto_sync = bus.wdata[`STLC_CTRL_AUTO_SYNC];
					if (bus.wdata[`STLC_CTRL_SYNC_NOW])
						sync_req = 1'b1;
					cnt_clr = bus.wdata[`STLC_CTRL_CNT_CLR];
				end
				`STLC_STATUS: clr_mask = bus.wdata[EN-1:0];
				`STLC_MASK:   next_mask = bus.wdata[EN-1:0];
				`STLC_RATE:
				begin
					// Raising the rate under USB mode would outrun alignment; refuse it
					if (mode == MODE_USB && bus.wdata[15:0] > `STLC_USB_MAX_MBPS)
						reg_ev[EV_MODE] = 1'b1;
					else
						next_rate = bus.wdata[15:0];
				end
				`STLC_CONV:   next_conv = bus.wdata[15:0];
				`STLC_PATLEN: next_patlen = bus.wdata[IW:0];
				`STLC_FILLER: next_filler = bus.wdata[9:0];
				`STLC_PAT:
				begin
					if (mode == MODE_8B10B && !sym_legal(bus.wdata[9:0]))
						reg_ev[EV_LOAD] = 1'b1;
					else
					begin
						next_pat[pat_idx] = bus.wdata[9:0];
						next_pat_flag[pat_idx] = mode == MODE_8B10B && disp_bad(bus.wdata[9:0], load_rd);
						reg_ev[EV_DISP] = next_pat_flag[pat_idx];
						next_load_rd = rd_after(bus.wdata[9:0], load_rd);
					end
				end
				default: ;
			endcase
		end
		// Set wins over a simultaneous write-one clear
		next_status = (status & ~clr_mask) | reg_ev | dp_ev;
		next_irq = |(next_status & next_mask);
		next_rdata = 32'h0;
		if (bus.rd)
		begin
			if (bus.addr >= `STLC_CNT_BASE && bus.addr[5:2] < 4'(CN) && bus.addr[7:6] == 2'h1)
				next_rdata = 32'(cnt[bus.addr[5:2]]);
			else
			begin
				unique case (bus.addr)
					`STLC_CTRL:     next_rdata = {25'h0, auto_sync, conv_user, src, mode};
					`STLC_STATUS:   next_rdata = 32'(status);
					`STLC_MASK:     next_rdata = 32'(mask);
					`STLC_RATE:     next_rdata = {16'h0, rate};
					`STLC_CONV:     next_rdata = {16'h0, conv};
					`STLC_PATLEN:   next_rdata = 32'(patlen);
					`STLC_FILLER:   next_rdata = {22'h0, filler};
					`STLC_PATFLAG:  next_rdata = 32'(pat_flag);
					`STLC_RATIO_NUM: next_rdata = 32'(ratio_num);
					`STLC_RATIO_DEN: next_rdata = 32'(ratio_den);
					default:        next_rdata = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode <= MODE_BIT;
			src <= SRC_SYM;
			conv_user <= 1'b0;
			auto_sync <= 1'b0;
			status <= '0;
			mask <= '0;
			rate <= `STLC_RATE_RST;
			conv <= `STLC_CONV_RST;
			patlen <= (IW+1)'(PAT_DEPTH);
			filler <= `STLC_FILLER_RST;
			pat <= '{default: 10'h0};
			pat_flag <= '0;
			load_rd <= 1'b0;
			rdata <= 32'h0;
			irq <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			src <= next_src;
			conv_user <= next_conv_user;
			auto_sync <= next_auto_sync;
			status <= next_status;
			mask <= next_mask;
			rate <= next_rate;
			conv <= next_conv;
			patlen <= next_patlen;
			filler <= next_filler;
			pat <= next_pat;
			pat_flag <= next_pat_flag;
			load_rd <= next_load_rd;
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// Comparison datapath
	// ----------------------------------------
	always_comb
	begin
		next_ptr = ptr;
		next_aligned = aligned;
		next_rd_rx = rd_rx;
		next_skp_st = skp_st;
		next_skp_len = skp_len;
		next_tail = tail;
		next_err_run = err_run;
		next_frame_bad = frame_bad;
		dp_ev = '0;
		cmp8 = 1'b0;
		adv = 1'b0;
		err_now = 1'b0;
		resync = 1'b0;
		be = 4'h0;
		for (int k = 0; k < CN; k++)
			inc[k] = '0;
		last = (patlen == '0) ? '0 : IW'(patlen - 1'b1);
		exp_sym = pat[ptr];
		sym8 = rx.data[7:0];
		usb = mode == MODE_USB;
		skp_hit = near8(sym8, SKP_SYM, usb);
		end_hit = near8(sym8, END_SYM, usb);
		eie_hit = near8(sym8, EIE_SYM, usb);
		if (rx.valid && !usb)
			next_aligned = 1'b1;
		if (rx.valid)
		begin
			unique case (mode)
				MODE_BIT:
				begin
					be = ones(rx.data ^ exp_sym);
					inc[CNT_BITS] = CNT_W'(10);
					inc[CNT_BERR] = CNT_W'(be);
					err_now = be != 4'h0;
					adv = 1'b1;
				end
				MODE_8B10B:
				begin
					next_rd_rx = rd_after(rx.data, rd_rx);
					if (is_filler(rx.data, filler))
						inc[CNT_FILL] = CNT_W'(1);
					else
					begin
						// Either disparity of the expected symbol is a match
						err_now = !is_filler(rx.data, exp_sym);
						be = (ones(rx.data ^ exp_sym) < ones(rx.data ^ ~exp_sym)) ?
							ones(rx.data ^ exp_sym) : ones(rx.data ^ ~exp_sym);
						inc[CNT_BITS] = CNT_W'(10);
						inc[CNT_BERR] = CNT_W'(be);
						inc[CNT_SYMS] = CNT_W'(1);
						inc[CNT_SERR] = CNT_W'(err_now);
						inc[CNT_ILL] = CNT_W'(!sym_legal(rx.data));
						inc[CNT_DISP] = CNT_W'(disp_bad(rx.data, rd_rx));
						adv = 1'b1;
					end
				end
				MODE_PCIE, MODE_USB:
				begin
					if (usb && !aligned)
					begin
						if (eie_hit)
						begin
							next_aligned = 1'b1;
							next_ptr = '0;
							dp_ev[EV_ALIGN] = 1'b1;
						end
					end
					else
					begin
						unique case (skp_st)
							SK_NONE:
							begin
								next_skp_len = 6'h1;
								next_tail = `STLC_SKP_TAIL;
								if (skp_hit)
									next_skp_st = SK_BODY;
								else if (end_hit)
									next_skp_st = SK_TAIL;
								else
									cmp8 = 1'b1;
							end
							SK_BODY:
							begin
								next_skp_len = skp_len + 6'h1;
								if (end_hit)
									next_skp_st = SK_TAIL;
								else if (!skp_hit)
								begin
									// Set broken off without its end symbol
									dp_ev[EV_SKPLEN] = 1'b1;
									next_skp_st = SK_NONE;
									cmp8 = 1'b1;
								end
							end
							SK_TAIL:
							begin
								// Tail symbols may differ; never compared
								next_skp_len = skp_len + 6'h1;
								next_tail = tail - 2'h1;
								if (tail == 2'h1)
								begin
									next_skp_st = SK_NONE;
									dp_ev[EV_SKPLEN] = !skp_len_ok(usb, skp_len + 6'h1);
								end
							end
						endcase
					end
				end
			endcase
		end
		if (cmp8)
		begin
			// Only payload symbols reach the bit counters
			be = ones({2'h0, sym8 ^ exp_sym[7:0]});
			inc[CNT_BITS] = CNT_W'(8);
			inc[CNT_BERR] = CNT_W'(be);
			err_now = be != 4'h0;
			adv = 1'b1;
		end
		dp_ev[EV_ERR] = err_now;
		nptr = (ptr == last) ? '0 : ptr + 1'b1;
		if (mode == MODE_8B10B && is_filler(pat[nptr], filler))
			nptr = (nptr == last) ? '0 : nptr + 1'b1;
		if (adv)
		begin
			next_ptr = nptr;
			next_err_run = err_now ? ((err_run == 8'hff) ? err_run : err_run + 8'h1) : 8'h0;
			next_frame_bad = (ptr == last) ? 1'b0 : (frame_bad | err_now);
			if (ptr == last)
			begin
				inc[CNT_FRAMES] = CNT_W'(1);
				inc[CNT_FERR] = CNT_W'(frame_bad | err_now);
			end
		end
		// Filler, illegal and disparity ratios stay low under slips, so no auto resync on them
		resync = auto_sync && (src == SRC_SYM || src == SRC_FRM) && err_now && err_run == 8'(RESYNC_RUN - 1);
		dp_ev[EV_RESYNC] = resync;
		if (resync || sync_req)
		begin
			next_ptr = '0;
			next_err_run = 8'h0;
			next_frame_bad = 1'b0;
			next_skp_st = SK_NONE;
			next_aligned = 1'b0;
		end
		for (int k = 0; k < CN; k++)
			next_cnt[k] = cnt_clr ? '0 : cnt[k] + inc[k];
		// One selected ratio feeds the calculated bit error ratio
		unit = (src == SRC_FRM) ? CNT_FRAMES : CNT_SYMS;
		factor = conv_user ? conv : ((src == SRC_FRM || src == SRC_FILL) ? 16'(patlen) : `STLC_AUTO_FACTOR);
		unique case (src)
			SRC_FRM:  next_ratio_num = cnt[CNT_FERR];
			SRC_FILL: next_ratio_num = cnt[CNT_FILL];
			SRC_ILL:  next_ratio_num = cnt[CNT_ILL];
			SRC_DISP: next_ratio_num = cnt[CNT_DISP];
			default:  next_ratio_num = cnt[CNT_SERR];
		endcase
		next_ratio_den = CNT_W'(cnt[unit] * factor);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ptr <= '0;
			aligned <= 1'b0;
			rd_rx <= 1'b0;
			skp_st <= SK_NONE;
			skp_len <= 6'h0;
			tail <= 2'h0;
			err_run <= 8'h0;
			frame_bad <= 1'b0;
			cnt <= '{default: '0};
			ratio_num <= '0;
			ratio_den <= '0;
		end
		else
		begin
			ptr <= next_ptr;
			aligned <= next_aligned;
			rd_rx <= next_rd_rx;
			skp_st <= next_skp_st;
			skp_len <= next_skp_len;
			tail <= next_tail;
			err_run <= next_err_run;
			frame_bad <= next_frame_bad;
			cnt <= next_cnt;
			ratio_num <= next_ratio_num;
			ratio_den <= next_ratio_den;
		end
	end
	assign sym_lock = aligned;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_mode_after_reset: assert property ($past(rst) |-> mode == MODE_BIT) else $error("mode not bit after reset");
	a_pcie_len_ok: assert property (mode == MODE_PCIE && rx.valid && skp_st == SK_TAIL && tail == 2'h1
		&& skp_len inside {6'd7, 6'd11, 6'd15, 6'd19, 6'd23} |=> !status[EV_SKPLEN] || $past(status[EV_SKPLEN]))
		else $error("valid pcie skip length flagged");
	a_usb_len_ok: assert property (mode == MODE_USB && rx.valid && skp_st == SK_TAIL && tail == 2'h1
		&& skp_len[0] && skp_len >= 6'd3 && skp_len <= 6'd39 |-> !dp_ev[EV_SKPLEN])
		else $error("valid usb skip length flagged");
	a_tail_uncounted: assert property (skp_st == SK_TAIL && !cnt_clr |=> $stable(cnt[CNT_BERR]) && $stable(cnt[CNT_BITS]))
		else $error("skip tail counted");
	a_skip_dropped: assert property (skp_st == SK_NONE && rx.valid && skp_hit && aligned && !cnt_clr
		&& (mode == MODE_PCIE || mode == MODE_USB) |=> $stable(cnt[CNT_BITS]) ##1 skp_st != SK_NONE || !rx.valid || sync_req)
		else $error("skip symbol compared");
	a_usb_wait_align: assert property (mode == MODE_USB && !aligned && !cnt_clr |=> $stable(cnt[CNT_BITS]))
		else $error("usb compared before alignment");
	a_one_bit_skip: assert property (mode == MODE_USB && aligned && skp_st == SK_NONE && rx.valid && !sync_req
		&& ones({2'h0, sym8 ^ SKP_SYM}) == 4'h1 |=> skp_st == SK_BODY) else $error("one-bit skip not corrected");
	a_usb_rate: assert property (mode == MODE_USB |-> rate <= `STLC_USB_MAX_MBPS) else $error("usb mode above rate limit");
	a_filler_ignored: assert property (mode == MODE_8B10B && rx.valid && is_filler(rx.data, filler) && !cnt_clr
		|=> $stable(cnt[CNT_SERR]) && cnt[CNT_FILL] == $past(cnt[CNT_FILL]) + 1'b1) else $error("filler not ignored");
	a_auto_factor: assert property (!conv_user && src == SRC_SYM |=> ratio_den == CNT_W'($past(cnt[CNT_SYMS]) * 10))
		else $error("automatic factor not ten");
	a_load_reject: assert property (bus.wr && bus.addr == `STLC_PAT && mode == MODE_8B10B
		&& !sym_legal(bus.wdata[9:0]) |=> status[EV_LOAD] && pat[$past(pat_idx)] == $past(pat[pat_idx]))
		else $error("invalid symbol loaded");
	c_pcie_skip: cover property (mode == MODE_PCIE && skp_st == SK_TAIL ##1 skp_st == SK_NONE);
	c_usb_align: cover property (mode == MODE_USB && $rose(aligned));
	c_auto_resync: cover property (resync);
	c_irq_rise: cover property ($rose(irq));
endmodule

// [core/stlc_regs.svh]
// Register map, field positions, reset values and counts of the loopback checker.
// Assumes a plain register port with 8-bit byte addresses and 32-bit data.
`ifndef STLC_REGS_SVH
`define STLC_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define STLC_CTRL      8'h00
`define STLC_STATUS    8'h04
`define STLC_MASK      8'h08
`define STLC_RATE      8'h0c
`define STLC_CONV      8'h10
`define STLC_PAT       8'h14
`define STLC_PATLEN    8'h18
`define STLC_FILLER    8'h1c
`define STLC_PATFLAG   8'h20
`define STLC_RATIO_NUM 8'h24
`define STLC_RATIO_DEN 8'h28
`define STLC_CNT_BASE  8'h40

// ----------------------------------------
// Fields
// ----------------------------------------
`define STLC_CTRL_MODE       0
`define STLC_CTRL_SRC        2
`define STLC_CTRL_CONV_USER  5
`define STLC_CTRL_AUTO_SYNC  6
`define STLC_CTRL_SYNC_NOW   7
`define STLC_CTRL_CNT_CLR    8
`define STLC_PAT_IDX         16

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define STLC_RATE_RST      16'h0000
`define STLC_CONV_RST      16'h000a
`define STLC_FILLER_RST    10'h000
`define STLC_USB_MAX_MBPS  16'h286e
`define STLC_AUTO_FACTOR   16'h000a
`define STLC_PCIE_SKP_MIN  6'h08
`define STLC_PCIE_SKP_MAX  6'h18
`define STLC_USB_SKP_MIN   6'h04
`define STLC_USB_SKP_MAX   6'h28
`define STLC_SKP_TAIL      2'h3
`define STLC_CNT_N         9
`define STLC_EV_N          7
`define STLC_RESYNC_RUN    8

`endif

// [core/stlc_pkg.sv]
// Types shared by the loopback checker and its bench.
// Assumes nothing of its surroundings.
package stlc_pkg;
	typedef enum logic [1:0] {
		MODE_BIT   = 2'h0,
		MODE_8B10B = 2'h1,
		MODE_PCIE  = 2'h2,
		MODE_USB   = 2'h3
	} stlc_mode_t;
	typedef enum logic [2:0] {
		SRC_SYM  = 3'h0,
		SRC_FRM  = 3'h1,
		SRC_FILL = 3'h2,
		SRC_ILL  = 3'h3,
		SRC_DISP = 3'h4
	} stlc_src_t;
	typedef enum logic [3:0] {
		CNT_BITS, CNT_BERR, CNT_SYMS, CNT_SERR, CNT_FERR,
		CNT_FRAMES, CNT_FILL, CNT_ILL, CNT_DISP
	} stlc_cnt_t;
	typedef enum logic [2:0] {
		EV_LOAD, EV_DISP, EV_SKPLEN, EV_MODE, EV_ALIGN, EV_ERR, EV_RESYNC
	} stlc_ev_t;
	typedef enum logic [1:0] {SK_NONE, SK_BODY, SK_TAIL} stlc_skp_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} stlc_bus_req_t;
	typedef struct packed {
		logic       valid;
		logic [9:0] data;
	} stlc_sym_t;
endpackage

// [dv/stlc_loop_dut.sv]
// Far-end model: the device under test looping received symbols back.
// Assumes symbols from the bench on clk; removes skip symbols on request.
`timescale 1ns/1ns
module stlc_loop_dut import stlc_pkg::*; #(
	parameter logic [7:0] SKP_SYM = 8'haa
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire stlc_sym_t  tx,
	input  wire logic [5:0] drop_n,
	output stlc_sym_t       rx
);
	logic [5:0] dropped;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx <= '0;
			dropped <= '0;
		end
		else if (tx.valid && tx.data[7:0] == SKP_SYM && dropped < drop_n)
		begin
			// Bench asks only for whole groups, so a set shrinks by four
			rx <= '{valid: 1'b0, data: ~rx.data};
			dropped <= dropped + 6'h01;
		end
		else
		begin
			// Idle line shows no stale symbol
			rx <= tx.valid ? tx : stlc_sym_t'{valid: 1'b0, data: ~rx.data};
			if (tx.valid && tx.data[7:0] != SKP_SYM)
				dropped <= '0;
		end
	end
endmodule

// [dv/stlc_checker_tb.sv]
// Self-checking bench of the loopback checker, register tasks and symbol stream.
// Assumes the loop model in front of rx and default pattern depth of 16.
`timescale 1ns/1ns
`include "stlc_regs.svh"
module stlc_checker_tb import stlc_pkg::*;;
	localparam logic [9:0] SKPW = 10'h0aa;
	localparam logic [9:0] ENDW = 10'h0e1;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	stlc_bus_req_t bus = '0;
	stlc_sym_t     tx = '0;
	stlc_sym_t     rx;
	logic [5:0]    drop_n = '0;
	logic [31:0]   rdata;
	logic          irq;
	logic          sym_lock;
	int            n_errors = 0;
	int            checks = 0;
	int            cyc = 0;

	always #2 clk = ~clk;

	stlc_checker #(.SKP_SYM(8'haa), .END_SYM(8'he1), .EIE_SYM(8'h00)) stlc_checker_i (
		.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .rx(rx), .irq(irq), .sym_lock(sym_lock));
	stlc_loop_dut #(.SKP_SYM(8'haa)) stlc_loop_dut_i (
		.clk(clk), .rst(rst), .tx(tx), .drop_n(drop_n), .rx(rx));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask
	// Bit 1 is irq, bit 0 is sym_lock; sampled off the edge
	task automatic pinc(input logic [31:0] e);
		#1 chk({30'h0, irq, sym_lock}, e);
		@(posedge clk);
	endtask
	task automatic snd(input logic [9:0] s, input int n);
		repeat (n)
		begin
			tx <= '{valid: 1'b1, data: s};
			@(posedge clk);
		end
	endtask
	task automatic idle();
		tx <= '{valid: 1'b0, data: ~tx.data};
		repeat (4) @(posedge clk);
	endtask
	task automatic skp(input int ns, input logic [9:0] sk, input logic [9:0] en, input logic [9:0] tl);
		snd(sk, ns);
		snd(en, 1);
		snd(tl, 3);
	endtask

	// ----------------------------------------
	// Hang guard
	// ----------------------------------------
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(`STLC_CTRL, 32'h0);
		rdc(`STLC_CONV, 32'ha);
		rdc(`STLC_STATUS, 32'h0);
		rdc(8'h3c, 32'h0);
		// Bit mode: full 10-bit compare against the all-zero pattern
		snd(10'h001, 1);
		snd(10'h000, 1);
		idle();
		rdc(`STLC_CNT_BASE, 32'd20);
		rdc(`STLC_CNT_BASE + 8'h4, 32'h1);
		wr(`STLC_STATUS, 32'h20);
		for (int m = 0; m < 3; m++)
		begin
			wr(`STLC_CTRL, 32'(m));
			rdc(`STLC_CTRL, 32'(m));
		end
		// USB mode refused above the rate ceiling, raises irq when unmasked
		wr(`STLC_RATE, 32'h286f);
		wr(`STLC_CTRL, 32'h3);
		rdc(`STLC_CTRL, 32'h2);
		wr(`STLC_MASK, 32'h8);
		pinc(32'h2);
		wr(`STLC_STATUS, 32'h8);
		pinc(32'h0);
		wr(`STLC_MASK, 32'h0);
		// PCIe: every legal set length, one shrunk by the far end
		wr(`STLC_CTRL, 32'h102);
		for (int l = 8; l <= 24; l += 4)
		begin
			skp(l - 4, SKPW, ENDW, 10'h3ff);
			snd(10'h0, 2);
		end
		drop_n <= 6'h04;
		skp(12, SKPW, ENDW, 10'h155);
		snd(10'h0, 2);
		drop_n <= 6'h00;
		idle();
		rdc(`STLC_CNT_BASE, 32'd96);
		rdc(`STLC_CNT_BASE + 8'h4, 32'h0);
		rdc(`STLC_STATUS, 32'h0);
		skp(6, SKPW, ENDW, 10'h0);
		snd(10'h00f, 1);
		idle();
		rdc(`STLC_STATUS, 32'h24);
		rdc(`STLC_CNT_BASE + 8'h4, 32'h4);
		// USB: nothing counted before idle-exit alignment
		wr(`STLC_STATUS, 32'h7f);
		wr(`STLC_RATE, 32'h286e);
		wr(`STLC_CTRL, 32'h103);
		rdc(`STLC_CTRL, 32'h3);
		wr(`STLC_RATE, 32'h286f);
		rdc(`STLC_RATE, 32'h286e);
		rdc(`STLC_STATUS, 32'h8);
		wr(`STLC_STATUS, 32'h8);
		snd(10'h05a, 4);
		idle();
		pinc(32'h0);
		rdc(`STLC_CNT_BASE + 8'h4, 32'h0);
		snd(10'h001, 1);
		idle();
		pinc(32'h1);
		skp(0, SKPW, ENDW ^ 10'h002, 10'h3ff);
		snd(10'h0, 1);
		skp(36, SKPW ^ 10'h010, ENDW, 10'h3ff);
		snd(10'h0, 1);
		idle();
		rdc(`STLC_CNT_BASE + 8'h4, 32'h0);
		rdc(`STLC_STATUS, 32'h10);
		skp(1, SKPW, ENDW, 10'h0);
		idle();
		rdc(`STLC_STATUS, 32'h14);
		wr(`STLC_STATUS, 32'h4);
		skp(38, SKPW, ENDW, 10'h0);
		idle();
		rdc(`STLC_STATUS, 32'h14);
		// 8B/10B: pattern load checks, then either disparity and a filler
		wr(`STLC_CTRL, 32'h101);
		wr(`STLC_STATUS, 32'h7f);
		wr(`STLC_PAT, 32'h007);
		rdc(`STLC_STATUS, 32'h1);
		wr(`STLC_PAT, 32'h0003f);
		wr(`STLC_PAT, 32'h1003f);
		rdc(`STLC_PATFLAG, 32'h2);
		wr(`STLC_PATLEN, 32'h2);
		wr(`STLC_FILLER, 32'h17c);
		snd(10'h3c0, 1);
		snd(10'h03f, 1);
		snd(10'h283, 1);
		snd(10'h03f, 1);
		snd(10'h3c0, 1);
		snd(10'h0f8, 1);
		idle();
		rdc(`STLC_CNT_BASE + 8'h8, 32'h5);
		rdc(`STLC_CNT_BASE + 8'hc, 32'h1);
		rdc(`STLC_CNT_BASE + 8'h18, 32'h1);
		rdc(`STLC_RATIO_NUM, 32'h1);
		rdc(`STLC_RATIO_DEN, 32'd50);
		wr(`STLC_CTRL, 32'h0d);
		rdc(`STLC_RATIO_DEN, 32'd50);
		wr(`STLC_CTRL, 32'h11);
		rdc(`STLC_RATIO_DEN, 32'd50);
		wr(`STLC_CTRL, 32'h09);
		rdc(`STLC_RATIO_DEN, 32'd10);
		wr(`STLC_CONV, 32'h3);
		wr(`STLC_CTRL, 32'h21);
		rdc(`STLC_RATIO_DEN, 32'd15);
		// Manual sync drops lock until the next symbol
		wr(`STLC_CTRL, 32'h91);
		pinc(32'h0);
		snd(10'h03f, 1);
		idle();
		pinc(32'h1);
		print_verdict();
	end
endmodule
